// ==== otp_pkg.sv ====
package otp_pkg;

   // ****************************************************************
   // spi frame and register map
   // ****************************************************************
   localparam logic [5:0] CT_ADDR     = 6'h3e;
   localparam logic [1:0] CMD_WRITE   = 2'h0;
   localparam logic [1:0] CMD_READ    = 2'h1;
   localparam logic [7:0] STATUS_BYTE = 8'h00;
   localparam int         OPC_MSB     = 23;
   localparam int         OPC_LSB     = 21;
   localparam int         DEF_MSB     = 20;
   localparam int         DEF_LSB     = 13;

   // operation codes
   localparam logic [2:0] OP_NONE   = 3'h0;
   localparam logic [2:0] OP_STD    = 3'h1;
   localparam logic [2:0] OP_MARGIN = 3'h2;
   localparam logic [2:0] OP_BLANK  = 3'h3;
   localparam logic [2:0] OP_BURN   = 3'h4;
   localparam logic [2:0] OP_EOT    = 3'h7;

   // ****************************************************************
   // timing, clock period and durations in ns
   // ****************************************************************
   localparam int unsigned CLK_NS      = 25;
   localparam int unsigned PRE_NS      = 2850;
   localparam int unsigned BIT_NS      = 401000;
   localparam int unsigned EOT_NS      = 404000;
   localparam int unsigned RD_NS       = 1000;
   localparam int unsigned PRE_CYC     = (PRE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned BIT_CYC_DEF = (BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned EOT_CYC_DEF = (EOT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RD_CYC      = (RD_NS + CLK_NS - 1) / CLK_NS;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef struct packed {
      logic [1:0]  cmd;
      logic [5:0]  addr;
      logic [23:0] data;
   } otp_frame_type;

   // register bits 23:12, top to bottom
   typedef struct packed {
      logic [2:0] op;
      logic [1:0] hc;
      logic [1:0] dac;
      logic [1:0] vt;
      logic [1:0] rsvd;
      logic       trim_finished_flag;
   } otp_trim_type;

   localparam otp_trim_type TRIM_RST = 12'h002;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRE  = 3'b001,
      ST_BURN = 3'b011,
      ST_EOTB = 3'b010,
      ST_READ = 3'b110
   } otp_state_type;

   typedef enum logic [1:0] {
      RM_STD    = 2'h0,
      RM_MARGIN = 2'h1,
      RM_BLANK  = 2'h2
   } otp_rmode_type;

endpackage : otp_pkg

// ==== otp_trim_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - three-bit opcode at top, resets zero
// - decode std, margin, blank, burn, end-trim
// - burn only with opcode 100, flag clear
// - defaults occupy bits 20 down to 13
// - odd parity over every frame, bit zero
// - cell reads one when resistance low
// - blank check raises threshold, loads 20:12
// - read at 111110 returns loaded result
// - burn lasts 2.85us plus 401us per bit
// - end-of-trim burn about 404us, thrice
// - margin read lowers threshold, loads result
module otp_trim_ctrl
   import otp_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYC_DEF,
   parameter int unsigned EOT_CYC = EOT_CYC_DEF
)(
   // system
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // spi link
   input  wire logic       sck_i,
   input  wire logic       csn_i,
   input  wire logic       sdi_i,
   output logic            sdo_o,
   // anti-fuse array
   input  wire logic [8:0] fuse_i,
   output logic [7:0]      burn_sel_o,
   output logic            burn_eot_o,
   output logic            read_en_o,
   output logic [1:0]      read_mode_o,
   // trim results
   output logic [7:0]      defaults_o,
   output logic            trim_finished_flag_o,
   output logic            busy_o
);
   localparam logic [15:0] PRE_LAST = 16'(PRE_CYC - 1);
   localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
   localparam logic [15:0] EOT_LAST = 16'(EOT_CYC - 1);
   localparam logic [15:0] RD_LAST  = 16'(RD_CYC - 1);
   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_q1_r;
   logic rst_n_r;
   // async assert, two-flop release
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_q1_r <= 1'b1;
         rst_n_r  <= rst_q1_r;
      end
   end
   // ****************************************************************
   // link domain: shift in, frame capture, shift out
   // ****************************************************************
   logic [4:0]    bit_cnt_r;
   logic [4:0]    bit_cnt_nxt;
   logic [30:0]   shift_r;
   logic [30:0]   shift_nxt;
   otp_frame_type frm_r;
   otp_frame_type frm_nxt;
   logic          frm_tgl_r;
   logic          frm_tgl_nxt;
   logic          sdo_nxt;
   logic [23:0]   shadow_r;
   logic [31:0]   resp_w;
   // status byte then register image
   assign resp_w = {STATUS_BYTE, shadow_r};
   // count bits, latch word on the 32nd edge
   always_comb begin
      bit_cnt_nxt = bit_cnt_r + 5'h1;
      shift_nxt   = {shift_r[29:0], sdi_i};
      frm_nxt     = frm_r;
      frm_tgl_nxt = frm_tgl_r;
      if (bit_cnt_r == 5'h1f) begin
         frm_nxt     = {shift_r, sdi_i};
         frm_tgl_nxt = ~frm_tgl_r;
      end
      sdo_nxt = resp_w[~bit_cnt_r]; // msb first
   end
   // bit counter cleared by chip select outside frames
   always_ff @(posedge sck_i or posedge csn_i) begin
      if (csn_i) begin
         bit_cnt_r <= 5'h0;
         shift_r   <= 31'h0;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         shift_r   <= shift_nxt;
      end
   end
   // captured frame held for the system domain
   always_ff @(posedge sck_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         frm_r     <= '0;
         frm_tgl_r <= 1'b0;
      end else begin
         frm_r     <= frm_nxt;
         frm_tgl_r <= frm_tgl_nxt;
      end
   end
   // serial out on falling edge, same frame
   always_ff @(negedge sck_i or posedge csn_i) begin
      if (csn_i) begin
         sdo_o <= 1'b0;
      end else begin
         sdo_o <= sdo_nxt;
      end
   end
   // ****************************************************************
   // crossings into the system domain
   // ****************************************************************
   logic [10:0] sy1_r;
   logic [10:0] sy2_r;
   logic        tgl_s3_r;
   logic        csn_s_w;
   logic        frm_evt_w;
   logic [8:0]  fuse_w;
   // two flops for chip select, toggle and fuse levels
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sy1_r    <= 11'h401;
         sy2_r    <= 11'h401;
         tgl_s3_r <= 1'b0;
      end else begin
         sy1_r    <= {csn_i, frm_tgl_r, fuse_i};
         sy2_r    <= sy1_r;
         tgl_s3_r <= sy2_r[9];
      end
   end
   assign csn_s_w   = sy2_r[10];
   assign frm_evt_w = sy2_r[9] ^ tgl_s3_r;
   assign fuse_w    = sy2_r[8:0]; // one means written cell
   // ****************************************************************
   // command decode
   // ****************************************************************
   otp_state_type state_r;
   otp_state_type state_nxt;
   otp_trim_type  trim_r;
   otp_trim_type  trim_nxt;
   logic [2:0]    op_w;
   logic          parity_ok_w;
   logic          is_write_w;
   logic          op_legal_w;
   logic          accept_w;
   assign op_w        = frm_r.data[OPC_MSB:OPC_LSB];
   assign parity_ok_w = ^frm_r;
   assign is_write_w  = (frm_r.cmd == CMD_WRITE) && (frm_r.addr == CT_ADDR);
   // reads any time idle, burns only before end of trim
   always_comb begin
      case (op_w)
         OP_STD, OP_MARGIN, OP_BLANK: op_legal_w = 1'b1;
         OP_BURN, OP_EOT:             op_legal_w = !trim_r.trim_finished_flag;
         default:                     op_legal_w = 1'b0;
      endcase
   end
   // refused frames leave everything alone
   assign accept_w = frm_evt_w && parity_ok_w && is_write_w
                     && op_legal_w && (state_r == ST_IDLE);
   // ****************************************************************
   // operation sequencer
   // ****************************************************************
   logic [15:0] tmr_r;
   logic [15:0] tmr_nxt;
   logic [7:0]  mask_r;
   logic [7:0]  mask_nxt;
   logic [7:0]  low_w;
   // lowest selected bit still to burn
   assign low_w = mask_r & (~mask_r + 8'h01);
   always_comb begin
      state_nxt = state_r;
      trim_nxt  = trim_r;
      mask_nxt  = mask_r;
      tmr_nxt   = tmr_r + 16'h1;
      case (state_r)
         ST_IDLE: begin
            tmr_nxt = 16'h0;
            if (accept_w) begin
               trim_nxt.op = op_w;
               case (op_w)
                  OP_BURN: begin
                     {trim_nxt.hc, trim_nxt.dac, trim_nxt.vt,
                      trim_nxt.rsvd} = frm_r.data[DEF_MSB:DEF_LSB];
                     mask_nxt  = frm_r.data[DEF_MSB:DEF_LSB];
                     state_nxt = ST_PRE;
                  end
                  OP_EOT:  state_nxt = ST_EOTB;
                  default: state_nxt = ST_READ;
               endcase
            end
         end
         ST_PRE: begin
            if (tmr_r == PRE_LAST) begin
               tmr_nxt   = 16'h0;
               state_nxt = (mask_r == 8'h00) ? ST_IDLE : ST_BURN;
            end
         end
         ST_BURN: begin
            if (tmr_r == BIT_LAST) begin
               tmr_nxt  = 16'h0;
               mask_nxt = mask_r & ~low_w;
               if ((mask_r & ~low_w) == 8'h00) begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_EOTB: begin
            if (tmr_r == EOT_LAST) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_READ: begin
            if (tmr_r == RD_LAST) begin
               {trim_nxt.hc, trim_nxt.dac, trim_nxt.vt,
                trim_nxt.rsvd} = fuse_w[8:1];
               trim_nxt.trim_finished_flag = fuse_w[0];
               state_nxt    = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            tmr_nxt   = 16'h0;
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ST_IDLE;
         trim_r  <= TRIM_RST;
         mask_r  <= 8'h00;
         tmr_r   <= 16'h0;
      end else begin
         state_r <= state_nxt;
         trim_r  <= trim_nxt;
         mask_r  <= mask_nxt;
         tmr_r   <= tmr_nxt;
      end
   end
   // ****************************************************************
   // read image and array outputs
   // ****************************************************************
   logic [23:0] shadow_nxt;
   logic [1:0]  rmode_w;
   // threshold follows the opcode that started the read
   always_comb begin
      case (trim_r.op)
         OP_MARGIN: rmode_w = RM_MARGIN;
         OP_BLANK:  rmode_w = RM_BLANK;
         default:   rmode_w = RM_STD;
      endcase
   end
   // image only moves while chip select is high
   always_comb begin
      shadow_nxt = shadow_r;
      if (csn_s_w) begin
         shadow_nxt = {trim_r, 11'h000, ~^{STATUS_BYTE, trim_r}};
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         shadow_r             <= {TRIM_RST, 11'h000,
                                  ~^{STATUS_BYTE, TRIM_RST}};
         burn_sel_o           <= 8'h00;
         burn_eot_o           <= 1'b0;
         read_en_o            <= 1'b0;
         read_mode_o          <= 2'h0;
         defaults_o           <= 8'h00;
         trim_finished_flag_o <= 1'b0;
         busy_o               <= 1'b0;
      end else begin
         shadow_r    <= shadow_nxt;
         burn_sel_o  <= (state_r == ST_BURN) ? low_w : 8'h00;
         burn_eot_o  <= (state_r == ST_EOTB);
         read_en_o   <= (state_r == ST_READ);
         read_mode_o <= rmode_w;
         defaults_o  <= {trim_r.hc, trim_r.dac, trim_r.vt,
                         trim_r.rsvd};
         trim_finished_flag_o <= trim_r.trim_finished_flag;
         busy_o               <= (state_r != ST_IDLE);
      end
   end
   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_r);
   a_refused_frame: assert property (
      frm_evt_w && !accept_w && state_r == ST_IDLE
      |=> state_r == ST_IDLE && trim_r == $past(trim_r))
      else $error("refused frame changed state");
   a_burn_gate: assert property (
      state_r == ST_IDLE && state_nxt == ST_PRE
      |-> !trim_r.trim_finished_flag && op_w == OP_BURN && parity_ok_w)
      else $error("burn started without permission");
   a_resp_parity: assert property (^resp_w)
      else $error("read frame parity not odd");
   a_opcode_load: assert property (
      accept_w |=> trim_r.op == $past(op_w))
      else $error("opcode field not loaded");
   a_pre_time: assert property (
      state_r == ST_PRE && state_nxt != ST_PRE |-> tmr_r == PRE_LAST)
      else $error("pre-burn time wrong");
   a_bit_time: assert property (
      state_r == ST_BURN && mask_nxt != mask_r
      |-> tmr_r == BIT_LAST ##1 $countones(mask_r) ==
          $countones($past(mask_r)) - 1)
      else $error("per-bit burn time wrong");
   a_burn_onehot: assert property (
      state_r == ST_BURN |=> $onehot(burn_sel_o))
      else $error("burn select not one-hot");
   a_eot_time: assert property (
      state_r == ST_EOTB && state_nxt == ST_IDLE |-> tmr_r == EOT_LAST)
      else $error("end-of-trim burn time wrong");
   a_read_load: assert property (
      state_r == ST_READ && state_nxt == ST_IDLE
      |=> {trim_r.hc, trim_r.dac, trim_r.vt, trim_r.rsvd, trim_r.trim_finished_flag}
          == $past(fuse_w))
      else $error("read result not loaded");
   a_blank_mode: assert property (
      state_r == ST_READ && trim_r.op == OP_BLANK |=> read_mode_o == RM_BLANK)
      else $error("blank check threshold not selected");
   c_burn_done: cover property (state_r == ST_BURN ##1 state_r == ST_IDLE);
   c_eot_done: cover property (state_r == ST_EOTB ##1 state_r == ST_IDLE);
   c_blank_read: cover property (read_en_o && read_mode_o == RM_BLANK);
   c_refused: cover property (frm_evt_w && !accept_w);
endmodule : otp_trim_ctrl
`default_nettype wire

// ==== otp_spi_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// spi host model, link clock runs only inside frames
// ****************************************************************
module otp_spi_host (
   // spi link
   input  wire logic sdo_i,
   output logic      sck_o,
   output logic      csn_o,
   output logic      sdi_o
);
   logic [31:0] resp;
   event        done;

   // idle link: chip select high, clock low
   initial begin
      sck_o = 1'b0;
      csn_o = 1'b1;
      sdi_o = 1'b0;
   end

   // one 32-bit frame, msb first, 12 ns link period
   task automatic xfer(input logic [31:0] f);
      int i;
      csn_o = 1'b0;
      #103;
      for (i = 31; i >= 0; i--) begin
         sdi_o   = f[i];
         #6;
         resp[i] = sdo_i;
         sck_o   = 1'b1;
         #6;
         sck_o   = 1'b0;
      end
      #6;
      csn_o = 1'b1;
      sdi_o = ~f[0];  // released line shows no stale level
      ->done;
      #150;
   endtask : xfer
endmodule : otp_spi_host
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
   begin n_tests++; if ((e) !== (g)) begin failures++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
   import otp_pkg::*;
   localparam int unsigned BITC = 20;
   localparam int unsigned EOTC = 30;
   logic         clk_i    = 1'b0;
   logic         rst_n_i  = 1'b0;
   logic [8:0]   fuse_i   = 9'h000;
   logic [8:0]   fuse_r   = 9'h000;
   wire logic    sck;
   wire logic    csn;
   wire logic    sdi;
   logic         sdo;
   logic [7:0]   burn_sel;
   logic         burn_eot;
   logic         read_en;
   logic [1:0]   read_mode;
   logic [1:0]   rmode;
   logic [7:0]   defaults;
   logic         flag;
   logic         busy;
   logic [31:0]  exp_f;
   otp_trim_type img = TRIM_RST;
   logic [31:0]  q[$];
   logic [2:0]   bad_ops[3] = '{3'h0, 3'h5, 3'h6};
   int           failures = 0;
   int           n_tests  = 0;
   int           bcnt     = 0;
   int           cyc      = 0;

   // ****************************************************************
   // clock, design and host
   // ****************************************************************
   always #12.5 clk_i = ~clk_i;

   otp_trim_ctrl #(.BIT_CYC(BITC), .EOT_CYC(EOTC)) uut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .csn_i(csn),
      .sdi_i(sdi), .sdo_o(sdo), .fuse_i(fuse_i), .burn_sel_o(burn_sel),
      .burn_eot_o(burn_eot), .read_en_o(read_en),
      .read_mode_o(read_mode), .defaults_o(defaults),
      .trim_finished_flag_o(flag), .busy_o(busy)
   );

   otp_spi_host u_host (
      .sdo_i(sdo), .sck_o(sck), .csn_o(csn), .sdi_o(sdi)
   );

   // fuse array: a cell under burn becomes written; burn cycle count
   always @(posedge clk_i) begin
      fuse_r <= fuse_r | {burn_sel, burn_eot};
      fuse_i <= fuse_r;
      if (burn_sel != 8'h00 || burn_eot) begin
         bcnt <= bcnt + 1;
      end
      if (read_en) begin
         rmode <= read_mode;
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   // every frame answer against the oldest expected note
   always @(u_host.done) begin
      exp_f = q.pop_front();
      `CHK("frame", exp_f, u_host.resp)
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] resp_of(input otp_trim_type t);
      logic [31:0] r;
      r    = {8'h00, t, 11'h000, 1'b0};
      r[0] = ~^r[31:1];
      return r;
   endfunction : resp_of

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // one frame, then wait idle and check the visible outcome
   task automatic op(input logic [1:0] c, input logic [5:0] a,
                     input logic [2:0] o, input logic [7:0] w,
                     input logic bad);
      logic [31:0] f;
      logic        ok;
      int          b0;
      int          n;
      logic [1:0]  exp_m;
      int          exp_b;
      f    = {c, a, o, w, 12'h000, 1'b0};
      f[0] = (~^f[31:1]) ^ bad;
      ok   = c == CMD_WRITE && a == CT_ADDR && !bad
             && o inside {OP_STD, OP_MARGIN, OP_BLANK, OP_BURN, OP_EOT}
             && !((o == OP_BURN || o == OP_EOT) && img.trim_finished_flag);
      b0   = bcnt;
      q.push_back(resp_of(img));
      u_host.xfer(f);
      if (ok) begin
         img.op = o;
         if (o == OP_BURN) begin
            img[8:1] = w;
         end
      end
      repeat (12) @(posedge clk_i);
      n = 0;
      while (busy !== 1'b0 && n < 5000) begin
         @(posedge clk_i);
         n++;
      end
      repeat (2) @(posedge clk_i);
      if (ok && o inside {OP_STD, OP_MARGIN, OP_BLANK}) begin
         img[8:0] = fuse_r;
         exp_m = (o == OP_STD) ? 2'h0 : (o == OP_MARGIN) ? 2'h1 : 2'h2;
         `CHK("read_mode", exp_m, rmode)
      end
      // burn cycles scale with selected bits, end-of-trim is one cell
      exp_b = 0;
      if (ok && o == OP_BURN) begin
         exp_b = BITC * $countones(w);
      end else if (ok && o == OP_EOT) begin
         exp_b = EOTC;
      end
      `CHK("burn_cycles", exp_b, bcnt - b0)
      `CHK("defaults", img[8:1], defaults)
      `CHK("flag", img.trim_finished_flag, flag)
   endtask : op

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [7:0] w;
      int         i;
      void'($urandom(32'hea28ac3f));
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      op(CMD_READ, CT_ADDR, OP_NONE, 8'h00, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_BLANK, 8'h00, 1'b0);
      `CHK("blank", 4'h0, defaults[5:2])
      // refused writes leave everything as it was
      op(CMD_WRITE, CT_ADDR, OP_BURN, 8'hff, 1'b1);
      op(CMD_WRITE, 6'h3d, OP_BURN, 8'hff, 1'b0);
      op(2'h3, CT_ADDR, OP_BURN, 8'hff, 1'b0);
      for (i = 0; i < 3; i++) begin
         op(CMD_WRITE, CT_ADDR, bad_ops[i], 8'hff, 1'b0);
      end
      // burn passes, an empty word, then verify reads
      w = 8'($urandom());
      op(CMD_WRITE, CT_ADDR, OP_BURN, w, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_BURN, w, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_BURN, 8'h00, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_MARGIN, 8'h00, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_STD, 8'h00, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_BLANK, 8'h00, 1'b0);
      // lock trimming, then burns are refused
      repeat (3) op(CMD_WRITE, CT_ADDR, OP_EOT, 8'h00, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_STD, 8'h00, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_BURN, 8'hff, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_EOT, 8'h00, 1'b0);
      op(CMD_WRITE, CT_ADDR, OP_MARGIN, 8'h00, 1'b0);
      op(CMD_READ, CT_ADDR, OP_NONE, 8'h00, 1'b0);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
